// ==== hw/mrs_sequencer.sv ====
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module mrs_sequencer #(
    parameter int unsigned RAMP_STEP_CYC = mrs_pkg::RAMP_STEP_CYC,
    parameter int unsigned PG_DELAY_CYC = mrs_pkg::PG_DELAY_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire mrs_pkg::mrs_sense_s sense_in,
    output mrs_pkg::mrs_drive_s drive,
    output logic [3:0] ref_code,
    output logic rail_ok_out_o,
    output logic rail_ok_out_oe,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [11:0] RAMP_LAST = 12'(RAMP_STEP_CYC - 1);
    localparam logic [11:0] PG_LAST = 12'(PG_DELAY_CYC - 1);

    mrs_pkg::mrs_sense_s sync1_reg;
    mrs_pkg::mrs_sense_s sense;
    mrs_pkg::mrs_sleep_e sleep_reg;
    mrs_pkg::mrs_sleep_e sleep_next;
    mrs_pkg::mrs_rail_e state_reg;
    mrs_pkg::mrs_dis_e dis_reg;
    logic [11:0] cnt_reg;
    logic been_good_reg;
    logic term_good_reg;
    logic ctrl_en_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_ev;
    logic good_d_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic w_lane0_reg;
    logic wr_fire;
    logic run;

    function automatic mrs_pkg::mrs_sleep_e decode_sleep(input logic sus_n, input logic off_n);
        if (!off_n)
        begin
            return mrs_pkg::SLP_OFF;
        end
        return sus_n ? mrs_pkg::SLP_ON : mrs_pkg::SLP_RAM;
    endfunction : decode_sleep

    function automatic logic is_mapped(input logic [7:0] a);
        return a == mrs_pkg::ADDR_CTRL || a == mrs_pkg::ADDR_STATUS
            || a == mrs_pkg::ADDR_IRQ_STAT || a == mrs_pkg::ADDR_IRQ_MASK;
    endfunction : is_mapped

    // two-stage synchroniser for every pin
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_reg <= '0;
            sense <= '0;
        end
        else
        begin
            sync1_reg <= sense_in;
            sense <= sync1_reg;
        end
    end

    assign sleep_next = decode_sleep(sense.suspend_ram_n, sense.soft_off_n);
    assign run = sleep_reg != mrs_pkg::SLP_OFF && ctrl_en_reg;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sleep_reg <= mrs_pkg::SLP_OFF;
        end
        else
        begin
            sleep_reg <= sleep_next;
        end
    end

    // main rail soft-start and power-good sequence
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= mrs_pkg::R_OFF;
            cnt_reg <= '0;
            ref_code <= mrs_pkg::REF_START;
        end
        else if (!run)
        begin
            state_reg <= mrs_pkg::R_OFF;
            cnt_reg <= '0;
            ref_code <= mrs_pkg::REF_START;
        end
        else
        begin
            case (state_reg)
                mrs_pkg::R_OFF:
                begin
                    state_reg <= mrs_pkg::R_START;
                    ref_code <= mrs_pkg::REF_START;
                    cnt_reg <= '0;
                end
                mrs_pkg::R_START:
                begin
                    if (sense.uv80)
                    begin
                        state_reg <= mrs_pkg::R_RAMP;
                        cnt_reg <= '0;
                    end
                end
                mrs_pkg::R_RAMP:
                begin
                    if (cnt_reg == RAMP_LAST)
                    begin
                        cnt_reg <= '0;
                        if (ref_code == mrs_pkg::REF_FINAL)
                        begin
                            state_reg <= mrs_pkg::R_WAITPG;
                        end
                        else
                        begin
                            ref_code <= ref_code + 4'h1;
                        end
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg + 12'h001;
                    end
                end
                mrs_pkg::R_WAITPG:
                begin
                    cnt_reg <= '0;
                    if (sense.pg95)
                    begin
                        state_reg <= mrs_pkg::R_DELAY;
                    end
                end
                mrs_pkg::R_DELAY:
                begin
                    if (!sense.pg95)
                    begin
                        state_reg <= mrs_pkg::R_WAITPG;
                    end
                    else if (cnt_reg == PG_LAST)
                    begin
                        state_reg <= mrs_pkg::R_GOOD;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg + 12'h001;
                    end
                end
                mrs_pkg::R_GOOD:
                begin
                    if (!sense.pg95)
                    begin
                        state_reg <= mrs_pkg::R_WAITPG;
                    end
                end
                default:
                begin
                    state_reg <= mrs_pkg::R_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            been_good_reg <= 1'b0;
        end
        else if (state_reg == mrs_pkg::R_OFF)
        begin
            been_good_reg <= 1'b0;
        end
        else if (state_reg == mrs_pkg::R_GOOD)
        begin
            been_good_reg <= 1'b1;
        end
    end

    // termination good window with its own hysteresis
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            term_good_reg <= 1'b0;
        end
        else if (!drive.term_en || sense.term_out10)
        begin
            term_good_reg <= 1'b0;
        end
        else if (sense.term_in5)
        begin
            term_good_reg <= 1'b1;
        end
    end

    // discharge selection while off
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dis_reg <= mrs_pkg::D_IDLE;
        end
        else if (run)
        begin
            dis_reg <= mrs_pkg::D_IDLE;
        end
        else
        begin
            case (dis_reg)
                mrs_pkg::D_IDLE:
                begin
                    if (sense.mode_bias)
                    begin
                        dis_reg <= mrs_pkg::D_HOLD;
                    end
                    else if (sense.mode_gnd)
                    begin
                        dis_reg <= mrs_pkg::D_NONTRACK;
                    end
                    else
                    begin
                        dis_reg <= mrs_pkg::D_TRACK;
                    end
                end
                mrs_pkg::D_TRACK:
                begin
                    if (sense.rail_floor)
                    begin
                        dis_reg <= mrs_pkg::D_NONTRACK;
                    end
                end
                mrs_pkg::D_NONTRACK, mrs_pkg::D_HOLD:
                begin
                    dis_reg <= dis_reg;
                end
                default:
                begin
                    dis_reg <= mrs_pkg::D_IDLE;
                end
            endcase
        end
    end

    // output drive, registered
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            drive <= '0;
            rail_ok_out_oe <= 1'b1;
        end
        else
        begin
            drive.rail_en <= run;
            drive.ref_en <= run;
            drive.term_en <= ctrl_en_reg && sleep_reg == mrs_pkg::SLP_ON;
            drive.term_highz <= ctrl_en_reg && sleep_reg == mrs_pkg::SLP_RAM;
            drive.term_ilim_low <= !term_good_reg;
            drive.trk_dis <= dis_reg == mrs_pkg::D_TRACK;
            drive.dis_sw <= dis_reg == mrs_pkg::D_NONTRACK;
            drive.ocp_half <= state_reg == mrs_pkg::R_START || state_reg == mrs_pkg::R_RAMP
                || (been_good_reg && !sense.pg95);
            drive.trip_fixed <= sense.sense_res;
            drive.off_extend <= run && sense.sw_off && sense.cur_over;
            rail_ok_out_oe <= state_reg != mrs_pkg::R_GOOD;
        end
    end

    assign rail_ok_out_o = 1'b0;

    // interrupt events
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            good_d_reg <= 1'b0;
        end
        else
        begin
            good_d_reg <= state_reg == mrs_pkg::R_GOOD;
        end
    end

    always_comb
    begin
        irq_ev = '0;
        irq_ev[mrs_pkg::IRQ_PG_RISE] = state_reg == mrs_pkg::R_GOOD && !good_d_reg;
        irq_ev[mrs_pkg::IRQ_PG_FALL] = state_reg != mrs_pkg::R_GOOD && good_d_reg;
        irq_ev[mrs_pkg::IRQ_OCP] = run && sense.sw_off && sense.cur_over && !drive.off_extend;
        irq_ev[mrs_pkg::IRQ_SLEEP] = sleep_next != sleep_reg;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_stat_reg <= '0;
        end
        else if (wr_fire && aw_addr_reg == mrs_pkg::ADDR_IRQ_STAT && w_lane0_reg)
        begin
            irq_stat_reg <= (irq_stat_reg & ~w_data_reg[3:0]) | irq_ev;
        end
        else
        begin
            irq_stat_reg <= irq_stat_reg | irq_ev;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // axi4-lite write channel
    assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_lane0_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mrs_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_lane0_reg <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr_reg) ? mrs_pkg::RESP_OKAY : mrs_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_en_reg <= mrs_pkg::CTRL_EN_RESET;
            irq_mask_reg <= '0;
        end
        else if (wr_fire && w_lane0_reg)
        begin
            if (aw_addr_reg == mrs_pkg::ADDR_CTRL)
            begin
                ctrl_en_reg <= w_data_reg[mrs_pkg::CTRL_EN_BIT];
            end
            if (aw_addr_reg == mrs_pkg::ADDR_IRQ_MASK)
            begin
                irq_mask_reg <= w_data_reg[3:0];
            end
        end
    end

    // axi4-lite read channel
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= mrs_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? mrs_pkg::RESP_OKAY : mrs_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                mrs_pkg::ADDR_CTRL: s_axi_rdata <= {31'h0, ctrl_en_reg};
                mrs_pkg::ADDR_STATUS: s_axi_rdata <= {16'h0, 2'(dis_reg), 2'(sleep_reg),
                    term_good_reg, 3'(state_reg), ref_code, 4'h0};
                mrs_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_reg};
                mrs_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_reg};
                default: s_axi_rdata <= 32'h0;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_ramp_done;
        state_reg == mrs_pkg::R_RAMP ##1 state_reg == mrs_pkg::R_WAITPG && !been_good_reg;
    endsequence
    sequence s_track_floor;
        dis_reg == mrs_pkg::D_TRACK && sense.rail_floor && !run;
    endsequence

    a_start_ref_half: assert property (state_reg == mrs_pkg::R_START |=>
        drive.ocp_half && ref_code == mrs_pkg::REF_START)
        else $error("start state without low reference and half threshold");
    a_ramp_step_up: assert property (state_reg == mrs_pkg::R_RAMP && run
        && cnt_reg == RAMP_LAST && ref_code != mrs_pkg::REF_FINAL
        |=> ref_code == $past(ref_code) + 4'h1)
        else $error("reference did not step");
    a_ramp_end_ocp: assert property (s_ramp_done |=> !drive.ocp_half)
        else $error("threshold not restored after ramp");
    a_pg_after_delay: assert property ($rose(state_reg == mrs_pkg::R_GOOD) |->
        $past(state_reg) == mrs_pkg::R_DELAY && $past(cnt_reg) == PG_LAST)
        else $error("power good released before delay");
    a_term_limit: assert property (!term_good_reg |=> drive.term_ilim_low)
        else $error("termination limit not reduced");
    a_term_normal: assert property (term_good_reg |=> !drive.term_ilim_low)
        else $error("termination limit not normal");
    a_pg_rail_only: assert property (##1 rail_ok_out_oe ==
        ($past(state_reg) != mrs_pkg::R_GOOD))
        else $error("power good not tied to rail state");
    a_s0_enable: assert property (sleep_reg == mrs_pkg::SLP_ON && ctrl_en_reg |=>
        drive.rail_en && drive.ref_en && drive.term_en && !drive.term_highz)
        else $error("full-on state not all enabled");
    a_s3_float: assert property (sleep_reg == mrs_pkg::SLP_RAM && ctrl_en_reg |=>
        drive.rail_en && drive.ref_en && !drive.term_en && drive.term_highz)
        else $error("suspend state wrong");
    a_track_switch: assert property (s_track_floor |=>
        dis_reg == mrs_pkg::D_NONTRACK ##1 drive.dis_sw && !drive.trk_dis)
        else $error("tracking discharge did not hand over");
    a_off_extend: assert property (run && sense.sw_off && sense.cur_over
        |=> drive.off_extend)
        else $error("off interval not extended");
    a_ocp_pg_half: assert property (been_good_reg && !sense.pg95 && run
        |=> drive.ocp_half)
        else $error("trip level not halved below power good");
endmodule : mrs_sequencer

// ==== common/mrs_pkg.sv ====
package mrs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned RAMP_TIME_NS = 85000;
    localparam int unsigned REF_STEPS = 16;
    localparam int unsigned RAMP_STEP_CYC = RAMP_TIME_NS / (CLK_PERIOD_NS * REF_STEPS);
    localparam int unsigned PG_DELAY_NS = 45000;
    localparam int unsigned PG_DELAY_CYC = (PG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 12;
    // reference dac: code 0 is 650 mV, code 15 is 750 mV
    localparam int unsigned REF_START_MV = 650;
    localparam int unsigned REF_FINAL_MV = 750;
    localparam int unsigned REF_W = 4;
    localparam logic [3:0] REF_START = 4'h0;
    localparam logic [3:0] REF_FINAL = 4'hF;
    localparam int unsigned TRIP_FIXED_MV = 60;
    localparam int unsigned DIS_FLOOR_MV = 200;
    localparam int unsigned TERM_ILIM_LOW_MA = 2200;
    localparam int unsigned TERM_ILIM_NORM_MA = 3800;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_PG_RISE = 0;
    localparam int unsigned IRQ_PG_FALL = 1;
    localparam int unsigned IRQ_OCP = 2;
    localparam int unsigned IRQ_SLEEP = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SLP_ON, SLP_RAM, SLP_OFF} mrs_sleep_e;
    typedef enum logic [2:0] {R_OFF, R_START, R_RAMP, R_WAITPG, R_DELAY, R_GOOD} mrs_rail_e;
    typedef enum logic [1:0] {D_IDLE, D_TRACK, D_NONTRACK, D_HOLD} mrs_dis_e;

    typedef struct packed {
        logic suspend_ram_n;
        logic soft_off_n;
        logic uv80;
        logic pg95;
        logic rail_floor;
        logic term_in5;
        logic term_out10;
        logic cur_over;
        logic sw_off;
        logic mode_bias;
        logic mode_gnd;
        logic sense_res;
    } mrs_sense_s;

    typedef struct packed {
        logic rail_en;
        logic ref_en;
        logic term_en;
        logic term_highz;
        logic term_ilim_low;
        logic trk_dis;
        logic dis_sw;
        logic ocp_half;
        logic trip_fixed;
        logic off_extend;
    } mrs_drive_s;
endpackage : mrs_pkg

// ==== tb/mrs_stage_model.sv ====
`timescale 1ns/1ns
// power stage stand-in: rail level as a small counter, comparators from it
module mrs_stage_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire mrs_pkg::mrs_drive_s drive,
    input wire logic [8:0] ctl,
    output mrs_pkg::mrs_sense_s sense
);
    logic [4:0] lvl;

    // rail charges while enabled, bleeds only through a discharge path
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            lvl <= 5'h00;
        else if (drive.rail_en && lvl != 5'h1F)
            lvl <= lvl + 5'h01;
        else if ((drive.trk_dis || drive.dis_sw) && lvl != 5'h00)
            lvl <= lvl - 5'h01;
    end

    // ctl: sleep pins, strap, current, off interval, sensing, sag, term fault
    assign sense = {ctl[8], ctl[7], lvl >= 5'h18, lvl >= 5'h1E && !ctl[1], lvl <= 5'h04,
        drive.term_en && lvl >= 5'h1E && !ctl[0], ctl[0], ctl[4], ctl[3], ctl[6], ctl[5],
        ctl[2]};
endmodule : mrs_stage_model

// ==== tb/memory_rail_sequencer_tb.sv ====
`timescale 1ns/1ns
module memory_rail_sequencer_tb;
    logic core_clk = 1'b0;
    logic rstn, ram_n, off_n, sag, tbad, ocur, swoff, sres;
    logic [1:0] strap;
    mrs_pkg::mrs_sense_s sense_in;
    mrs_pkg::mrs_drive_s drive;
    logic [3:0] ref_code, wstrb;
    logic oe, irq, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rnd;
    logic [1:0] bresp, rresp;
    logic [36:0] exq[$];
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    integer seed = 32'h4B77;

    always #10 core_clk = ~core_clk;

    mrs_sequencer #(.RAMP_STEP_CYC(2), .PG_DELAY_CYC(4)) mrs_sequencer_inst (
        .core_clk(core_clk), .rstn(rstn), .sense_in(sense_in), .drive(drive),
        .ref_code(ref_code), .rail_ok_out_o(), .rail_ok_out_oe(oe), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    mrs_stage_model mrs_stage_model_inst (.core_clk(core_clk), .rstn(rstn), .drive(drive),
        .ctl({ram_n, off_n, strap, ocur, swoff, sres, sag, tbad}), .sense(sense_in));

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask : check

    task note(input logic [2:0] k, input logic [33:0] v);
        exq.push_back({k, v});
    endtask : note

    function automatic logic [33:0] obs(input logic [2:0] k);
        case (k)
            3'h2: return {27'h0, drive.rail_en, drive.ref_en, drive.term_en, drive.term_highz,
                drive.term_ilim_low, drive.trk_dis, drive.dis_sw};
            3'h3: return {30'h0, ref_code};
            3'h4: return {33'h0, oe};
            3'h5: return {33'h0, irq};
            default: return {31'h0, drive.ocp_half, drive.trip_fixed, drive.off_extend};
        endcase
    endfunction : obs

    // port notes are due at once, bus notes when their answer is taken
    always @(negedge core_clk)
    begin
        while (exq.size() > 0 && exq[0][36:35] != 2'h0)
        begin
            check(obs(exq[0][36:34]), exq[0][33:0]);
            void'(exq.pop_front());
        end
        if (exq.size() > 0 && (exq[0][34] ? rvalid && rready : bvalid && bready))
        begin
            check(exq[0][34] ? {rresp, rdata} : {bresp, 32'h0}, exq[0][33:0]);
            void'(exq.pop_front());
        end
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        note(3'h0, {r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge core_clk);
            aw = aw && !awready;
            w = w && !wready;
            awvalid <= aw;
            wvalid <= w;
        end
        do @(posedge core_clk); while (!bvalid);
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        note(3'h1, {r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (!rvalid);
        rready <= 1'b0;
    endtask : rd

    task up;
        ram_n <= 1'b1;
        off_n <= 1'b1;
        while (ref_code !== 4'h1) @(posedge core_clk);
        note(3'h6, {31'h0, 1'b1, sres, 1'b0});
        for (int k = 1; k < 16; k++)
        begin
            note(3'h3, {30'h0, k[3:0]});
            note(3'h4, 34'h1);
            repeat (2) @(posedge core_clk);
        end
        note(3'h4, 34'h1);
        while (oe !== 1'b0) @(posedge core_clk);
        note(3'h6, {32'h0, sres, 1'b0});
        note(3'h2, 34'h70);
    endtask : up

    initial
    begin
        {rstn, ram_n, off_n, sag, tbad, ocur, swoff, sres} = 8'h00;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        strap = 2'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        rnd = $random(seed);
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        sres <= rnd[0];
        @(posedge core_clk);
        rd(mrs_pkg::ADDR_CTRL, mrs_pkg::RESP_OKAY, 32'h1);
        rd(mrs_pkg::ADDR_IRQ_MASK, mrs_pkg::RESP_OKAY, 32'h0);
        rd(8'h10, mrs_pkg::RESP_SLVERR, 32'h0);
        wr(8'h14, 32'hFF, mrs_pkg::RESP_SLVERR);
        up();
        rd(mrs_pkg::ADDR_STATUS, mrs_pkg::RESP_OKAY, 32'hDF0);
        rd(mrs_pkg::ADDR_IRQ_STAT, mrs_pkg::RESP_OKAY, 32'h9);
        note(3'h5, 34'h0);
        wr(mrs_pkg::ADDR_IRQ_MASK, 32'h3, mrs_pkg::RESP_OKAY);
        repeat (3) @(posedge core_clk);
        note(3'h5, 34'h1);
        wr(mrs_pkg::ADDR_IRQ_STAT, 32'h1, mrs_pkg::RESP_OKAY);
        repeat (3) @(posedge core_clk);
        note(3'h5, 34'h0);
        rd(mrs_pkg::ADDR_IRQ_STAT, mrs_pkg::RESP_OKAY, 32'h8);
        tbad <= 1'b1;
        repeat (6) @(posedge core_clk);
        note(3'h2, 34'h74);
        note(3'h4, 34'h0);
        tbad <= 1'b0;
        repeat (6) @(posedge core_clk);
        note(3'h2, 34'h70);
        sag <= 1'b1;
        repeat (6) @(posedge core_clk);
        note(3'h6, {31'h0, 1'b1, sres, 1'b0});
        note(3'h4, 34'h1);
        note(3'h5, 34'h1);
        sag <= 1'b0;
        repeat (14) @(posedge core_clk);
        note(3'h4, 34'h0);
        swoff <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            rnd = $random(seed);
            ocur <= rnd[0];
            repeat (5) @(posedge core_clk);
            note(3'h6, {32'h0, sres, rnd[0]});
        end
        {ocur, swoff} <= 2'h0;
        ram_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        note(3'h2, 34'h6C);
        for (int s = 2; s >= 0; s--)
        begin
            strap <= s[1:0];
            {ram_n, off_n} <= 2'h0;
            repeat (8) @(posedge core_clk);
            note(3'h2, s == 2 ? 34'h04 : (s == 1 ? 34'h05 : 34'h06));
            repeat (40) @(posedge core_clk);
            note(3'h2, s == 2 ? 34'h04 : 34'h05);
            up();
        end
        wr(mrs_pkg::ADDR_CTRL, 32'h0, mrs_pkg::RESP_OKAY);
        repeat (3) @(posedge core_clk);
        note(3'h2, 34'h06);
        rd(mrs_pkg::ADDR_CTRL, mrs_pkg::RESP_OKAY, 32'h0);
        repeat (2) @(posedge core_clk);
        report_and_stop();
    end
endmodule : memory_rail_sequencer_tb
